// ===== verilog/switch_diag_pkg.sv
// Shared constants and types for the quad switch fault logic
package switch_diag_pkg;
  localparam int NUM_CH = 4;
  localparam int CLK_PERIOD_NS = 100;
  // Standby deglitch time in ns, plain default
  localparam int LOW_OFF_NS = 2000;
  // Least time, so round up to whole cycles
  localparam int LOW_OFF_CYC = (LOW_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] LOW_OFF_CNT = CNT_W'(LOW_OFF_CYC);
  localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
  // Current limit figures: percent of external setting, internal in mA
  localparam logic [6:0] LIMIT_FULL_PCT = 7'h64;
  localparam logic [6:0] LIMIT_EXT_TSD_PCT = 7'h46;
  localparam logic [13:0] LIMIT_INT_MA = 14'h2AF8;
  localparam logic [13:0] LIMIT_INT_TSD_MA = 14'h1964;
  // Positions of the flag groups in the synchroniser vector
  localparam int GRP_CL = 0;
  localparam int GRP_OL = 1;
  localparam int GRP_HOT = 2;
  localparam int GRP_COOL = 3;
  localparam int GRP_CLR = 4;
  localparam int GRP_RISE = 5;
  localparam int GRP_RCOOL = 6;
  localparam int NUM_GRP = 7;
  // Thermal shutdown state of one channel
  typedef enum logic [1:0] {TH_OK, TH_OFF, TH_RETRY} therm_state_e;
endpackage

// ===== verilog/chan_thermal.sv
// Per-channel thermal shutdown and heat rise protection cell
`timescale 1ns/1ps
module chan_thermal (
  input  wire logic clk_in,     // System clock
  input  wire logic rst_in,     // Synchronous reset
  input  wire logic on_in,      // Channel enable
  input  wire logic policy_in,  // High latches off
  input  wire logic hot_in,     // Above overheat limit
  input  wire logic cool_in,    // Below limit minus hysteresis
  input  wire logic clr_in,     // Below clear level
  input  wire logic rise_in,    // Heat rise above limit
  input  wire logic rcool_in,   // Heat rise below limit minus hysteresis
  output logic      drive_out,  // Output stage on
  output logic      fault_out,  // Thermal fault flag
  output logic      reduced_out // Reduced current limit
);
  import switch_diag_pkg::*;

  typedef struct packed {
    therm_state_e state;
    logic         on_prev;
    logic         reduced;
    logic         rise_off;
  } cell_s;

  localparam cell_s CELL_RST = '{state: TH_OK, on_prev: 1'b0, reduced: 1'b0, rise_off: 1'b0};

  cell_s st_reg;
  cell_s st_next;
  logic  toggle;

  // Any enable edge counts as a toggle
  assign toggle = on_in != st_reg.on_prev;

  // Next state of the cell
  always_comb
  begin
    st_next = st_reg;
    st_next.on_prev = on_in;
    unique case (st_reg.state)
      TH_OFF:   if (!policy_in && cool_in) st_next.state = TH_RETRY;
      TH_RETRY: if (clr_in) st_next.state = TH_OK;
      TH_OK:    st_next.state = TH_OK;
      default:  st_next.state = TH_OK;
    endcase
    if (toggle)
      st_next.state = TH_OK;
    if (!on_in)
      st_next.reduced = 1'b0;
    if (on_in && hot_in)
    begin
      st_next.state = TH_OFF;
      st_next.reduced = 1'b1;
    end
    if (rcool_in || !on_in)
      st_next.rise_off = 1'b0;
    if (on_in && rise_in)
      st_next.rise_off = 1'b1;
  end

  // State register
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      st_reg <= CELL_RST;
    else
      st_reg <= st_next;
  end

  assign drive_out = on_in && st_reg.state != TH_OFF && !st_reg.rise_off;
  assign fault_out = st_reg.state != TH_OK || st_reg.rise_off;
  assign reduced_out = st_reg.reduced;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_trip_off:
  assert property (on_in && hot_in |=> !drive_out && fault_out && reduced_out)
    else $error("thermal trip did not turn channel off");
  a_latch_hold:
  assert property (st_reg.state == TH_OFF && policy_in && !toggle |=> st_reg.state == TH_OFF)
    else $error("latched channel left off state without toggle");
  a_retry_start:
  assert property (st_reg.state == TH_OFF && !policy_in && cool_in && !toggle && !hot_in
    |=> st_reg.state == TH_RETRY ##1 (drive_out || !on_in))
    else $error("auto retry did not restart output");
  a_policy_fall:
  assert property (st_reg.state == TH_OFF && $fell(policy_in) && cool_in && !toggle
    && !hot_in |=> st_reg.state != TH_OFF)
    else $error("policy fall did not switch to auto retry");
  a_rise_cycle:
  assert property (on_in && rise_in |=> !drive_out && fault_out)
    else $error("heat rise protection misbehaved");
  a_rise_recover:
  assert property (rcool_in && !rise_in |=> !st_reg.rise_off)
    else $error("heat rise protection did not recover");
endmodule // chan_thermal

// ===== verilog/quad_switch_fault_diag.sv
// Fault detection, sense mux and thermal policy of a quad high-side switch
`timescale 1ns/1ps
module quad_switch_fault_diag (
  input  wire logic                                CLK_IN,            // System clock
  input  wire logic                                RST_IN,            // Synchronous reset
  input  wire logic                                DIAG_GATE_IN,      // Diagnostics gate
  input  wire logic [switch_diag_pkg::NUM_CH-1:0]  CHAN_ON_IN,        // Channel enables
  input  wire logic                                MUX_HIGH_BIT_IN,   // Sense mux high bit
  input  wire logic                                MUX_LOW_BIT_IN,    // Sense mux low bit
  input  wire logic                                OVERHEAT_POLICY_IN,// High latches off
  input  wire logic                                INT_LIMIT_IN,      // Internal limit in use
  input  wire logic [switch_diag_pkg::NUM_CH-1:0]  CUR_LIMIT_IN,      // Current limit hit
  input  wire logic [switch_diag_pkg::NUM_CH-1:0]  OPEN_LOAD_IN,      // Rail near supply
  input  wire logic [switch_diag_pkg::NUM_CH-1:0]  OVERHEAT_IN,       // Over overheat limit
  input  wire logic [switch_diag_pkg::NUM_CH-1:0]  OVERHEAT_COOL_IN,  // Below limit minus hyst
  input  wire logic [switch_diag_pkg::NUM_CH-1:0]  OVERHEAT_CLEAR_IN, // Below clear level
  input  wire logic [switch_diag_pkg::NUM_CH-1:0]  HEAT_RISE_IN,      // Heat rise over limit
  input  wire logic [switch_diag_pkg::NUM_CH-1:0]  HEAT_RISE_COOL_IN, // Heat rise below hyst
  output logic      [switch_diag_pkg::NUM_CH-1:0]  RAIL_DRIVE_OUT,    // Switched rail on
  output logic      [switch_diag_pkg::NUM_CH-1:0]  PROTECT_OUT,       // Protection active
  output logic      [switch_diag_pkg::NUM_CH-1:0]  LIMIT_REDUCED_OUT, // Reduced limit
  output logic      [switch_diag_pkg::NUM_CH-1:0]  CHAN_FAULT_OUT,    // Per-channel fault
  output logic                                     SENSE_OE_OUT,      // Sense driven
  output logic      [1:0]                          SENSE_CHAN_OUT,    // Routed channel
  output logic                                     SENSE_FAULT_OUT,   // Sense at fault level
  output logic                                     SENSE_LINEAR_OUT,  // Sense in linear region
  output logic                                     FAULT_LINE_OUT,    // Fault line level
  output logic                                     FAULT_OE_OUT,      // Fault line pulled low
  output logic      [6:0]                          LIMIT_PCT_OUT,     // Ext limit percent
  output logic      [13:0]                         LIMIT_MA_OUT,      // Int limit in mA
  output logic                                     STANDBY_OUT        // Standby mode
);
  import switch_diag_pkg::*;

  localparam int FLAG_W = NUM_GRP * NUM_CH;

  typedef struct packed {
    logic [FLAG_W-1:0] flag_s1;
    logic [FLAG_W-1:0] flag_s2;
    logic [CNT_W-1:0]  low_cnt;
    logic              standby;
    logic [NUM_CH-1:0] drive;
    logic [NUM_CH-1:0] protect;
    logic [NUM_CH-1:0] reduced;
    logic [NUM_CH-1:0] chfault;
    logic              sense_oe;
    logic [1:0]        sense_chan;
    logic              sense_fault;
    logic              sense_lin;
    logic              fault_oe;
    logic [6:0]        pct;
    logic [13:0]       ma;
  } top_s;

  localparam top_s TOP_RST = '{pct: LIMIT_FULL_PCT, ma: LIMIT_INT_MA, low_cnt: CNT_RST,
                               default: '0};

  // Pick one channel group out of the flag vector
  function automatic logic [NUM_CH-1:0] grp(input logic [FLAG_W-1:0] v, input int g);
    return v[g*NUM_CH +: NUM_CH];
  endfunction

  top_s              st_reg;
  top_s              st_next;
  logic [FLAG_W-1:0] raw_flags;
  logic [NUM_CH-1:0] cell_drive;
  logic [NUM_CH-1:0] cell_fault;
  logic [NUM_CH-1:0] cell_red;
  logic [NUM_CH-1:0] ch_fault;
  logic [1:0]        sel;
  logic              quiet;
  logic [NUM_CH-1:0] cl_f;    // Synced current limit flags
  logic [NUM_CH-1:0] hot_f;   // Synced overheat flags
  logic [NUM_CH-1:0] cool_f;  // Synced overheat cool flags
  logic [NUM_CH-1:0] clr_f;   // Synced overheat clear flags
  logic [NUM_CH-1:0] rise_f;  // Synced heat rise flags
  logic [NUM_CH-1:0] rcool_f; // Synced heat rise cool flags

  assign raw_flags = {HEAT_RISE_COOL_IN, HEAT_RISE_IN, OVERHEAT_CLEAR_IN, OVERHEAT_COOL_IN,
                      OVERHEAT_IN, OPEN_LOAD_IN, CUR_LIMIT_IN};
  assign sel = {MUX_HIGH_BIT_IN, MUX_LOW_BIT_IN};
  assign quiet = !DIAG_GATE_IN && CHAN_ON_IN == '0;

  // Synchronised flag groups split out per kind
  assign cl_f = grp(st_reg.flag_s2, GRP_CL);
  assign hot_f = grp(st_reg.flag_s2, GRP_HOT);
  assign cool_f = grp(st_reg.flag_s2, GRP_COOL);
  assign clr_f = grp(st_reg.flag_s2, GRP_CLR);
  assign rise_f = grp(st_reg.flag_s2, GRP_RISE);
  assign rcool_f = grp(st_reg.flag_s2, GRP_RCOOL);

  // Thermal cell per channel
  for (genvar i = 0; i < NUM_CH; i++)
  begin : g_cell
    chan_thermal u_cell (
      .clk_in      (CLK_IN),
      .rst_in      (RST_IN),
      .on_in       (CHAN_ON_IN[i]),
      .policy_in   (OVERHEAT_POLICY_IN),
      .hot_in      (hot_f[i]),
      .cool_in     (cool_f[i]),
      .clr_in      (clr_f[i]),
      .rise_in     (rise_f[i]),
      .rcool_in    (rcool_f[i]),
      .drive_out   (cell_drive[i]),
      .fault_out   (cell_fault[i]),
      .reduced_out (cell_red[i])
    );
  end

  // Per-channel fault from flags and thermal state
  always_comb
  begin
    ch_fault = (CHAN_ON_IN & cl_f)
             | (~CHAN_ON_IN & grp(st_reg.flag_s2, GRP_OL))
             | cell_fault;
  end

  // Next state of the top
  always_comb
  begin
    st_next = st_reg;
    st_next.flag_s1 = raw_flags;
    st_next.flag_s2 = st_reg.flag_s1;
    st_next.drive = cell_drive;
    st_next.protect = CHAN_ON_IN;
    st_next.reduced = cell_red;
    st_next.chfault = ch_fault;
    st_next.sense_oe = DIAG_GATE_IN;
    st_next.sense_chan = DIAG_GATE_IN ? sel : 2'h0;
    st_next.sense_fault = DIAG_GATE_IN && ch_fault[sel];
    st_next.sense_lin = DIAG_GATE_IN && !ch_fault[sel] && cell_drive[sel];
    st_next.fault_oe = DIAG_GATE_IN && |ch_fault;
    if (cell_red[sel])
    begin
      st_next.pct = INT_LIMIT_IN ? LIMIT_FULL_PCT : LIMIT_EXT_TSD_PCT;
      st_next.ma = LIMIT_INT_TSD_MA;
    end
    else
    begin
      st_next.pct = LIMIT_FULL_PCT;
      st_next.ma = LIMIT_INT_MA;
    end
    if (quiet)
    begin
      if (st_reg.low_cnt < LOW_OFF_CNT)
        st_next.low_cnt = st_reg.low_cnt + 8'h01;
    end
    else
      st_next.low_cnt = CNT_RST;
    st_next.standby = quiet && st_reg.low_cnt == LOW_OFF_CNT;
  end

  // State register
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
      st_reg <= TOP_RST;
    else
      st_reg <= st_next;
  end

  // Outputs straight from the state register, fault line data tied low
  assign RAIL_DRIVE_OUT = st_reg.drive;
  assign PROTECT_OUT = st_reg.protect;
  assign LIMIT_REDUCED_OUT = st_reg.reduced;
  assign CHAN_FAULT_OUT = st_reg.chfault;
  assign SENSE_OE_OUT = st_reg.sense_oe;
  assign SENSE_CHAN_OUT = st_reg.sense_chan;
  assign SENSE_FAULT_OUT = st_reg.sense_fault;
  assign SENSE_LINEAR_OUT = st_reg.sense_lin;
  assign FAULT_LINE_OUT = 1'b0;
  assign FAULT_OE_OUT = st_reg.fault_oe;
  assign LIMIT_PCT_OUT = st_reg.pct;
  assign LIMIT_MA_OUT = st_reg.ma;
  assign STANDBY_OUT = st_reg.standby;

  // Quiet run length seen by the checks
  logic [CNT_W-1:0] quiet_run;
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
      quiet_run <= CNT_RST;
    else if (!quiet)
      quiet_run <= CNT_RST;
    else if (quiet_run != 8'hFF)
      quiet_run <= quiet_run + 8'h01;
  end

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);

  // Condition held long enough to pass the synchroniser
  sequence s_overload;
    (DIAG_GATE_IN && CHAN_ON_IN[0] && CUR_LIMIT_IN[0]) [*4];
  endsequence
  sequence s_off_near_supply;
    (DIAG_GATE_IN && !CHAN_ON_IN[1] && OPEN_LOAD_IN[1]) [*4];
  endsequence

  a_gate_hiz:
  assert property (!DIAG_GATE_IN |=> !SENSE_OE_OUT && !FAULT_OE_OUT && !SENSE_FAULT_OUT)
    else $error("pins driven while diagnostics gate low");
  a_mux_route:
  assert property (DIAG_GATE_IN |=> SENSE_OE_OUT
    && SENSE_CHAN_OUT == $past({MUX_HIGH_BIT_IN, MUX_LOW_BIT_IN}))
    else $error("sense not routed to selected channel");
  a_overload_fault:
  assert property (s_overload |-> FAULT_OE_OUT && CHAN_FAULT_OUT[0])
    else $error("current limit not reported");
  a_off_fault:
  assert property (s_off_near_supply |-> FAULT_OE_OUT && CHAN_FAULT_OUT[1])
    else $error("off-state open load not reported");
  a_on_open_quiet:
  assert property (CHAN_ON_IN[2] && !cl_f[2] && !cell_fault[2]
    |=> !CHAN_FAULT_OUT[2])
    else $error("on-state open load reported as fault");
  a_sense_fault:
  assert property (SENSE_FAULT_OUT |-> FAULT_OE_OUT && CHAN_FAULT_OUT[SENSE_CHAN_OUT])
    else $error("sense fault level without channel fault");
  a_reduced_limit:
  assert property (cell_red[sel] && !INT_LIMIT_IN |=> LIMIT_PCT_OUT == LIMIT_EXT_TSD_PCT
    && LIMIT_MA_OUT == LIMIT_INT_TSD_MA)
    else $error("limit not reduced after thermal trip");
  a_standby_wait:
  assert property (STANDBY_OUT |-> quiet_run > LOW_OFF_CNT)
    else $error("standby entered before deglitch time");
  a_standby_exit:
  assert property (!quiet |=> !STANDBY_OUT ##1 (quiet_run == 8'h00 || !STANDBY_OUT))
    else $error("standby held with activity present");
endmodule // quad_switch_fault_diag

// ===== tb/host_mcu_model.sv
// Controller side model: pulled-up fault line and sense pin readback
`timescale 1ns/1ps
module host_mcu_model (
  input  wire logic clk_in,         // System clock
  input  wire logic fault_line_in,  // Fault pin data
  input  wire logic fault_oe_in,    // Fault pin pulled low
  input  wire logic sense_oe_in,    // Sense pin driven
  input  wire logic sense_fault_in, // Sense at fault level
  output logic      fault_n_out,    // Fault line as the controller reads it
  output logic      sense_high_out  // Sense pin reads high
);
  logic wander_reg; // Pattern seen on a floating sense pin

  // Floating pin toggles so a stale value never passes as valid
  initial wander_reg = 1'b0;
  always @(posedge clk_in)
  begin
    wander_reg <= ~wander_reg;
  end

  assign fault_n_out = (fault_oe_in && !fault_line_in) ? 1'b0 : 1'b1;
  assign sense_high_out = sense_oe_in ? sense_fault_in : wander_reg;
endmodule // host_mcu_model

// ===== tb/quad_switch_fault_diag_bench.sv
// Self-checking bench for the quad switch fault logic
`timescale 1ns/1ps
module quad_switch_fault_diag_bench;
  import switch_diag_pkg::*;
  typedef struct {int sel; logic [13:0] val;} note_s;
  localparam int SETTLE = 6;
  logic              clk_in, rst_in, gate, mux_hi, mux_lo, pol, int_lim;
  logic [NUM_CH-1:0] chan_on, cur_lim, open_ld, hot, cool, clr, rise, rcool;
  logic [NUM_CH-1:0] drive, protect, reduced, chan_flt;
  logic              sense_oe, sense_flt, sense_lin, flt_line, flt_oe, standby, flt_n, sense_hi;
  logic [1:0]        sense_ch;
  logic [6:0]        lim_pct;
  logic [13:0]       lim_ma;
  note_s             notes[$];
  int                err_count, comparisons, s;

  // Free-running system clock
  initial
  begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  quad_switch_fault_diag dut_u (
    .CLK_IN(clk_in), .RST_IN(rst_in), .DIAG_GATE_IN(gate), .CHAN_ON_IN(chan_on),
    .MUX_HIGH_BIT_IN(mux_hi), .MUX_LOW_BIT_IN(mux_lo), .OVERHEAT_POLICY_IN(pol),
    .INT_LIMIT_IN(int_lim), .CUR_LIMIT_IN(cur_lim), .OPEN_LOAD_IN(open_ld),
    .OVERHEAT_IN(hot), .OVERHEAT_COOL_IN(cool), .OVERHEAT_CLEAR_IN(clr),
    .HEAT_RISE_IN(rise), .HEAT_RISE_COOL_IN(rcool), .RAIL_DRIVE_OUT(drive),
    .PROTECT_OUT(protect), .LIMIT_REDUCED_OUT(reduced), .CHAN_FAULT_OUT(chan_flt),
    .SENSE_OE_OUT(sense_oe), .SENSE_CHAN_OUT(sense_ch), .SENSE_FAULT_OUT(sense_flt),
    .SENSE_LINEAR_OUT(sense_lin), .FAULT_LINE_OUT(flt_line), .FAULT_OE_OUT(flt_oe),
    .LIMIT_PCT_OUT(lim_pct), .LIMIT_MA_OUT(lim_ma), .STANDBY_OUT(standby));

  host_mcu_model host_u (
    .clk_in(clk_in), .fault_line_in(flt_line), .fault_oe_in(flt_oe),
    .sense_oe_in(sense_oe), .sense_fault_in(sense_flt), .fault_n_out(flt_n),
    .sense_high_out(sense_hi));

  // Observed value for each kind of note
  function automatic logic [13:0] seen(input int sel);
    case (sel)
      0: seen = 14'(drive);
      1: seen = 14'(protect);
      2: seen = 14'(reduced);
      3: seen = 14'(chan_flt);
      4: seen = 14'(sense_oe);
      5: seen = 14'(sense_ch);
      6: seen = 14'(sense_flt);
      7: seen = 14'(flt_n);
      8: seen = 14'(standby);
      9: seen = 14'(lim_pct);
      10: seen = lim_ma;
      11: seen = 14'(sense_lin);
      default: seen = 14'(sense_hi);
    endcase
  endfunction

  task automatic report(input note_s n, input string what);
    comparisons++;
    if (seen(n.sel) !== n.val)
    begin
      err_count++;
      $display("[FAIL] %0t %s %0d got %h expected %h", $time, what, n.sel, seen(n.sel), n.val);
    end
  endtask
  task automatic check_flags(input note_s n);
    report(n, "flag group");
  endtask
  task automatic check_limit(input note_s n);
    report(n, "limit value");
  endtask

  task automatic note_out(input int sel, input logic [13:0] val);
    notes.push_back('{sel, val});
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic pick(input int ch);
    {mux_hi, mux_lo} = 2'(ch);
  endtask

  task automatic give_verdict();
    if (err_count == 0 && comparisons > 0)
    begin
      $display("Simulation passed");
    end
    else
    begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // All pending notes are compared once outputs of the last edge have settled
  always @(negedge clk_in)
  begin
    #1;
    while (notes.size() > 0)
    begin
      if (notes[0].sel == 9 || notes[0].sel == 10) check_limit(notes.pop_front());
      else check_flags(notes.pop_front());
    end
  end

  // Watchdog well beyond the planned run length
  initial
  begin
    repeat (5000) @(posedge clk_in);
    err_count++;
    $display("[FAIL] %0t run did not finish", $time);
    give_verdict();
  end

  // Main stimulus, driven on the falling edge
  initial
  begin
    {rst_in, gate, mux_hi, mux_lo, pol, int_lim} = 6'h20;
    {chan_on, cur_lim, open_ld, hot, cool, clr, rise, rcool} = 32'h0;
    err_count = 0;
    comparisons = 0;
    void'($urandom(57));
    wait_cyc(10);
    note_out(9, 14'h0064); // full external limit
    note_out(10, 14'h2AF8); // full internal limit
    note_out(7, 14'h0001); // line released
    rst_in = 1'b0;
    gate = 1'b1;
    chan_on = 4'hF;
    for (int k = 0; k < 7; k++)
    begin
      s = (k < 4) ? k : int'($urandom_range(3));
      pick(s);
      wait_cyc(2);
      note_out(5, 14'(s)); // routed channel
      note_out(11, 14'h0001); // linear sense
    end
    gate = 1'b0;
    chan_on = 4'h5;
    cur_lim = 4'hF;
    wait_cyc(SETTLE);
    note_out(4, 14'h0000); // sense released
    note_out(7, 14'h0001); // fault line released
    note_out(1, 14'h0005); // protection follows enables
    gate = 1'b1;
    chan_on = 4'hF;
    for (int i = 0; i < NUM_CH; i++)
    begin
      pick(i);
      cur_lim = 4'h1 << i;
      wait_cyc(SETTLE);
      note_out(3, 14'(4'h1 << i)); // channel fault
      note_out(7, 14'h0000); // line pulled low
      note_out(12, 14'h0001); // sense at fault level
      pick((i + 1) % 4);
      wait_cyc(2);
      note_out(6, 14'h0000); // healthy channel selected
      cur_lim = 4'h0;
      wait_cyc(SETTLE);
      note_out(7, 14'h0001); // recovers by itself
    end
    chan_on = 4'hE;
    cur_lim = 4'h1;
    wait_cyc(SETTLE);
    note_out(3, 14'h0000); // disabled channel ignored
    cur_lim = 4'h0;
    chan_on = 4'hB;
    open_ld = 4'h6;
    pick(2);
    wait_cyc(SETTLE);
    note_out(3, 14'h0004); // off-state open load
    note_out(6, 14'h0001); // reported like open load
    note_out(7, 14'h0000); // line pulled low
    pick(1);
    chan_on = 4'hF;
    wait_cyc(SETTLE);
    note_out(6, 14'h0000); // on-state open load silent
    note_out(7, 14'h0001); // enable held high, line quiet
    open_ld = 4'h0;
    pol = 1'b1;
    hot = 4'h2;
    wait_cyc(SETTLE);
    note_out(0, 14'h000D); // only that channel off
    note_out(3, 14'h0002); // per-channel flag
    note_out(2, 14'h0002); // reduced limit
    note_out(9, 14'h0046); // seventy percent
    hot = 4'h0;
    cool = 4'h2;
    clr = 4'h2;
    wait_cyc(SETTLE);
    note_out(0, 14'h000D); // latched off
    note_out(3, 14'h0002); // flag held
    chan_on = 4'hD;
    wait_cyc(2);
    chan_on = 4'hF;
    wait_cyc(SETTLE);
    note_out(0, 14'h000F); // toggle restores output
    note_out(3, 14'h0000); // toggle clears flag
    {cool, clr} = 8'h0;
    int_lim = 1'b1;
    hot = 4'h2;
    wait_cyc(SETTLE);
    note_out(10, 14'h1964); // internal reduced limit
    hot = 4'h0;
    pol = 1'b0;
    wait_cyc(2);
    cool = 4'h2;
    wait_cyc(SETTLE);
    note_out(0, 14'h000F); // retry after policy drop
    note_out(3, 14'h0002); // flag stays while warm
    clr = 4'h2;
    wait_cyc(SETTLE);
    note_out(3, 14'h0000); // flag clears at clear level
    {cool, clr} = 8'h0;
    rise = 4'h8;
    wait_cyc(SETTLE);
    note_out(0, 14'h0007); // output off
    note_out(3, 14'h0008); // flag set
    rise = 4'h0;
    rcool = 4'h8;
    wait_cyc(SETTLE);
    note_out(0, 14'h000F); // output recovers
    note_out(3, 14'h0000); // flag clears
    rcool = 4'h0;
    gate = 1'b0;
    chan_on = 4'h0;
    wait_cyc(15);
    note_out(8, 14'h0000); // still in deglitch
    chan_on = 4'h1;
    wait_cyc(1);
    chan_on = 4'h0;
    wait_cyc(15);
    note_out(8, 14'h0000); // short pulse restarts count
    wait_cyc(12);
    note_out(8, 14'h0001); // standby reached
    gate = 1'b1;
    wait_cyc(3);
    note_out(8, 14'h0000); // activity leaves standby
    wait_cyc(2);
    give_verdict();
  end
endmodule // quad_switch_fault_diag_bench
